// file: rtl/pir_pkg.sv
/*
 Package for the I2C slave front end of the power-management block:
 bus addresses, register offsets, field positions, reset values.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pir_pkg;
   localparam logic [6:0] PIR_ADDR_REGS    = 7'h48;
   localparam logic [6:0] PIR_ADDR_MEM     = 7'h58;
   localparam logic [7:0] PIR_OFS_IDENT    = 8'h00;
   localparam logic [7:0] PIR_OFS_MEMREV   = 8'h01;
   localparam logic [7:0] PIR_OFS_PAD      = 8'h02;
   localparam logic [7:0] PIR_PAD_RESET    = 8'h38;
   localparam logic [7:0] PIR_PAD_WMASK    = 8'h3B;
   localparam logic [7:0] PIR_READ_UNMAP   = 8'h00;
   localparam logic [7:0] PIR_RSVD_ZERO    = 8'h00;
   localparam int         PIR_BIT_IO_STYLE = 5;
   localparam int         PIR_BIT_IO_DIR   = 4;
   localparam int         PIR_BIT_IO_LEVEL = 3;
   localparam int         PIR_BIT_OP_STYLE = 1;
   localparam int         PIR_BIT_OP_LEVEL = 0;
   localparam logic [11:0] PIR_MEM_TOP     = 12'hFFF;
   localparam int         PIR_SYNC_DIV     = 8;

   // Bus condition events from the pin watcher
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
      logic sda;
   } pir_bus_ev_s;

   // Pad drive set for one pin
   typedef struct packed {
      logic oe_n;
      logic out;
   } pir_pad_s;
endpackage : pir_pkg

// file: rtl/pir_bus_watch.sv
/*
 Pin watcher: synchronises the serial clock and data lines and reports
 start, stop and clock edges as one-cycle pulses.
 Assumes pins are asynchronous to core_clk and slow against 200 MHz.
*/
`timescale 1ns/10ps
`default_nettype none
module pir_bus_watch (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   // Pins
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   // Events
   output var pir_pkg::pir_bus_ev_s ev
);
   import pir_pkg::*;

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_prev;
   logic       sda_prev;

   // Two-stage synchronisers; only stage two is read beyond here
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
      end
   end

   // History for edge detection
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
      end
   end

   // Data moving under a high clock is only ever start or stop
   always_comb begin
      ev.start = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
      ev.stop  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
      ev.rise  = scl_sync[1] & ~scl_prev;
      ev.fall  = ~scl_sync[1] & scl_prev;
      ev.sda   = sda_sync[1];
   end
endmodule : pir_bus_watch
`default_nettype wire

// file: rtl/pir_i2c_slave.sv
/*
 I2C slave front end with identification, memory revision and pad control
 registers, plus a port toward the 4 kByte one-time memory.
 Assumes undervoltage_lockout is already synchronous to core_clk and the
 memory answers reads combinationally from mem_addr.
*/
// Overview of operation
// - register write: offset byte then one data
// - memory write: low, high address, then data
// - undefined register offsets read as zero
// - data changes only while clock low
// - transfers framed by start and stop
// - acknowledge each byte, low through clock high
// - master nack ends read; release data
// - lockout or stop returns interface idle
// - spurious power-up start runs sync clock
// - identification read-only, device and revision
// - memory revision read-only, bit seven zero
// - bit five selects I/O pin style
// - bit four selects I/O pin direction
// - bit three sets I/O pin level
// - bit one selects output pin style
// - bit zero sets output pin level
// - multi-byte transfers; stretch clock on memory writes
`timescale 1ns/10ps
`default_nettype none
module pir_i2c_slave #(
   parameter logic [3:0] DEVICE_CODE   = 4'hA,  // Arbitrary value
   parameter logic [3:0] DIE_REV_CODE  = 4'h1,  // Arbitrary value
   parameter logic [6:0] MEM_REV_CODE  = 7'h2A  // Arbitrary value
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic               undervoltage_lockout,
   // Serial bus pins
   input  wire logic               scl_in,
   output logic                    scl_out,
   output logic                    scl_oe_n,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe_n,
   // Memory port
   output logic [11:0]             mem_addr,
   output logic [7:0]              mem_wdata,
   output logic                    mem_we,
   input  wire logic               mem_busy,
   input  wire logic [7:0]         mem_rdata,
   // Pads
   output logic                    io_pin_out,
   output logic                    io_pin_oe_n,
   output logic                    io_pin_push_pull,
   input  wire logic               io_pin_in,
   output logic                    second_regulator_en,
   output logic                    out_pin_level,
   output logic                    out_pin_oe_n,
   output logic                    out_pin_output_style,
   // Status
   output logic                    sync_clk_on
);
   import pir_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_RX   = 6'b000100,
      ST_TX   = 6'b001000,
      ST_ACK  = 6'b010000,
      ST_MACK = 6'b100000
   } pir_state_e;

   pir_bus_ev_s ev;
   pir_state_e  state;
   logic [7:0]  shreg;
   logic [2:0]  bit_cnt;
   logic        is_mem;
   logic        rd_mode;
   logic [1:0]  byte_idx;
   logic [7:0]  reg_ptr;
   logic [15:0] mem_ptr;
   logic [7:0]  pad;
   logic [7:0]  ident;
   logic [7:0]  memrev;
   logic        lock_q;
   logic        armed;
   logic        hold_scl;
   logic        sync_tick;
   logic [2:0]  sync_cnt;
   logic        io_in_q1;
   logic        io_in_q2;
   logic        ack_drive;
   logic [7:0]  rd_byte;

   pir_bus_watch u_watch (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .ev       (ev)
   );

   // Read data mux; undefined offsets and beyond-range memory read zero
   always_comb begin
      rd_byte = PIR_READ_UNMAP;
      if (is_mem) begin
         if (mem_ptr[15:12] == 4'h0)
            rd_byte = mem_rdata;
      end else begin
         case (reg_ptr)
            PIR_OFS_IDENT:  rd_byte = ident;
            PIR_OFS_MEMREV: rd_byte = memrev;
            PIR_OFS_PAD:    rd_byte = pad;
            default:        rd_byte = PIR_READ_UNMAP;
         endcase
      end
   end

   // Lockout release loads the read-only contents
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lock_q <= 1'b1;
         ident  <= PIR_RSVD_ZERO;
         memrev <= PIR_RSVD_ZERO;
      end else begin
         lock_q <= undervoltage_lockout;
         if (lock_q && !undervoltage_lockout) begin
            ident  <= {DEVICE_CODE, DIE_REV_CODE};
            memrev <= {1'b0, MEM_REV_CODE};
         end
      end
   end

   // Spurious start before the first clean stop: sync clock until stop
   always_ff @(posedge core_clk) begin
      if (sys_rst || undervoltage_lockout) begin
         armed       <= 1'b0;
         sync_clk_on <= 1'b0;
      end else if (ev.stop) begin
         armed       <= 1'b1;
         sync_clk_on <= 1'b0;
      end else if (!armed && ev.start) begin
         sync_clk_on <= 1'b1;
      end
   end

   // Divided tick of the synchronization clock
   always_ff @(posedge core_clk) begin
      if (sys_rst || !sync_clk_on) begin
         sync_cnt  <= 3'h0;
         sync_tick <= 1'b0;
      end else begin
         sync_cnt  <= sync_cnt + 3'h1;
         sync_tick <= (sync_cnt == 3'(PIR_SYNC_DIV - 1));
      end
   end

   // Main protocol engine
   always_ff @(posedge core_clk) begin
      if (sys_rst || undervoltage_lockout || ev.stop) begin
         state    <= ST_IDLE;
         bit_cnt  <= 3'h0;
         shreg    <= 8'h00;
         is_mem   <= 1'b0;
         rd_mode  <= 1'b0;
         byte_idx <= 2'h0;
         ack_drive <= 1'b0;
         mem_we   <= 1'b0;
      end else if (ev.start) begin
         state     <= ST_ADDR;
         bit_cnt   <= 3'h0;
         shreg     <= 8'h00; // Stale byte must not decode as an address
         byte_idx  <= 2'h0;
         ack_drive <= 1'b0;
         mem_we    <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         case (state)
            ST_IDLE: begin
            end
            ST_ADDR, ST_RX: begin
               if (ev.rise) begin
                  shreg   <= {shreg[6:0], ev.sda};
                  bit_cnt <= bit_cnt + 3'h1;
               end else if (ev.fall && bit_cnt == 3'h0 && shreg != 8'h00 &&
                            state == ST_ADDR) begin
                  if (shreg[7:1] == PIR_ADDR_REGS || shreg[7:1] == PIR_ADDR_MEM) begin
                     is_mem    <= (shreg[7:1] == PIR_ADDR_MEM);
                     rd_mode   <= shreg[0];
                     ack_drive <= 1'b1;
                     state     <= ST_ACK;
                     if (shreg[0])
                        shreg <= 8'h00;
                  end else begin
                     state <= ST_IDLE;
                  end
               end else if (ev.fall && bit_cnt == 3'h0 && state == ST_RX) begin
                  ack_drive <= 1'b1;
                  state     <= ST_ACK;
                  if (!is_mem && byte_idx == 2'h0) begin
                     reg_ptr  <= shreg;
                     byte_idx <= 2'h1;
                  end else if (is_mem && byte_idx == 2'h0) begin
                     mem_ptr[7:0] <= shreg;
                     byte_idx     <= 2'h1;
                  end else if (is_mem && byte_idx == 2'h1) begin
                     mem_ptr[15:8] <= shreg;
                     byte_idx      <= 2'h2;
                  end else if (is_mem) begin
                     if (mem_ptr[15:12] == 4'h0)
                        mem_we <= 1'b1;
                     mem_wdata <= shreg;
                     mem_ptr   <= mem_ptr + 16'h1;
                  end else begin
                     reg_ptr <= reg_ptr + 8'h1;
                  end
               end
            end
            ST_ACK: begin
               // Hold acknowledge through the whole ninth high phase
               if (ev.fall && !hold_scl) begin
                  ack_drive <= 1'b0;
                  bit_cnt   <= 3'h0;
                  if (rd_mode) begin
                     shreg <= rd_byte;
                     state <= ST_TX;
                  end else begin
                     state <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (ev.fall) begin
                  shreg   <= {shreg[6:0], 1'b1};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7)
                     state <= ST_MACK;
               end
            end
            ST_MACK: begin
               if (ev.rise) begin
                  if (ev.sda) begin
                     state <= ST_IDLE;
                  end else if (is_mem) begin
                     mem_ptr <= mem_ptr + 16'h1;
                  end else begin
                     reg_ptr <= reg_ptr + 8'h1;
                  end
               end else if (ev.fall && state == ST_MACK) begin
                  shreg   <= rd_byte;
                  bit_cnt <= 3'h0;
                  state   <= ST_TX;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Pad register: only writable fields take the data byte
   always_ff @(posedge core_clk) begin
      if (sys_rst || undervoltage_lockout) begin
         pad <= PIR_PAD_RESET;
      end else if (state == ST_RX && ev.fall && bit_cnt == 3'h0 && !is_mem &&
                   byte_idx == 2'h1 && reg_ptr == PIR_OFS_PAD) begin
         pad <= (shreg & PIR_PAD_WMASK) | (pad & ~PIR_PAD_WMASK);
      end
   end

   // Stretch the clock while the one-time memory write runs
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         hold_scl <= 1'b0;
      else
         hold_scl <= (state == ST_ACK) && is_mem && (mem_busy || mem_we);
   end

   // Bus drivers; releasing data after a read keeps the line high
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sda_out  <= 1'b0;
         sda_oe_n <= 1'b1;
         scl_out  <= 1'b0;
         scl_oe_n <= 1'b1;
      end else begin
         sda_out  <= 1'b0;
         sda_oe_n <= ~(ack_drive || (state == ST_TX && !shreg[7]));
         scl_out  <= 1'b0;
         scl_oe_n <= ~hold_scl;
      end
   end

   // Pad input is asynchronous, two flops before use
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         io_in_q1 <= 1'b0;
         io_in_q2 <= 1'b0;
      end else begin
         io_in_q1 <= io_pin_in;
         io_in_q2 <= io_in_q1;
      end
   end

   // Pad controls, all registered
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         io_pin_out           <= 1'b0;
         io_pin_oe_n          <= 1'b1;
         io_pin_push_pull     <= 1'b0;
         second_regulator_en  <= 1'b0;
         out_pin_level        <= 1'b0;
         out_pin_oe_n         <= 1'b1;
         out_pin_output_style <= 1'b0;
         mem_addr             <= 12'h000;
      end else begin
         io_pin_push_pull <= ~pad[PIR_BIT_IO_STYLE];
         io_pin_out       <= pad[PIR_BIT_IO_LEVEL];
         // Open drain releases on one; push-pull drives the one
         io_pin_oe_n <= ~pad[PIR_BIT_IO_DIR] ||
                        (pad[PIR_BIT_IO_STYLE] && pad[PIR_BIT_IO_LEVEL]);
         second_regulator_en  <= ~pad[PIR_BIT_IO_DIR] && io_in_q2;
         out_pin_output_style <= pad[PIR_BIT_OP_STYLE];
         out_pin_level        <= pad[PIR_BIT_OP_LEVEL];
         out_pin_oe_n <= pad[PIR_BIT_OP_STYLE] && pad[PIR_BIT_OP_LEVEL];
         mem_addr     <= mem_ptr[11:0] & PIR_MEM_TOP;
      end
   end
endmodule : pir_i2c_slave
`default_nettype wire

// file: test/pir_i2c_slave_checker.sv
/* Checker on the slave's ports.
 Assumes the master holds SCL low well over 4 cycles. */
`timescale 1ns/10ps
`default_nettype none
module pir_i2c_slave_checker (
   // Clock, reset, lockout
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic undervoltage_lockout,
   // Bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic scl_oe_n,
   input wire logic scl_out,
   // Memory and pads
   input wire logic mem_we,
   input wire logic mem_busy,
   input wire logic io_pin_oe_n,
   input wire logic io_pin_push_pull,
   input wire logic second_regulator_en,
   input wire logic out_pin_level,
   input wire logic out_pin_oe_n,
   input wire logic out_pin_output_style,
   input wire logic sync_clk_on
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Pad settle one edge after any reset, hence the past terms
   ack_low_a: assert property (!sda_oe_n |-> !sda_out)
      else $error("data line driven high");
   scl_low_a: assert property (!scl_oe_n |-> !scl_out)
      else $error("clock line driven high");
   sda_steady_a: assert property (scl_in [*6] |-> $stable(sda_oe_n))
      else $error("data moved while clock high");
   lock_idle_a: assert property (undervoltage_lockout |=> sda_oe_n && scl_oe_n)
      else $error("bus held in lockout");
   pad_dflt_a: assert property ($fell(undervoltage_lockout) |=> io_pin_oe_n
      && !io_pin_push_pull && !second_regulator_en && !out_pin_output_style && !out_pin_oe_n)
      else $error("pad default wrong");
   out_od_a: assert property (out_pin_output_style && out_pin_level |-> out_pin_oe_n)
      else $error("open drain high driven");
   out_low_a: assert property (!out_pin_level && !$past(sys_rst)
      && !$past(undervoltage_lockout) |-> !out_pin_oe_n) else $error("low not driven");
   reg_in_a: assert property (second_regulator_en |-> io_pin_oe_n)
      else $error("input pin driven");
   we_pulse_a: assert property (mem_we |=> !mem_we)
      else $error("write strobe too long");
   stretch_end_a: assert property ($fell(mem_busy) |-> ##[1:8] scl_oe_n)
      else $error("clock held after busy");
   sync_off_a: assert property ($rose(sda_in) && scl_in && $past(scl_in)
      |-> ##[1:8] !sync_clk_on) else $error("sync clock left on");
endmodule : pir_i2c_slave_checker
bind pir_i2c_slave pir_i2c_slave_checker i_chk (.core_clk, .sys_rst, .undervoltage_lockout,
   .scl_in, .sda_in, .sda_out, .sda_oe_n, .scl_oe_n, .scl_out, .mem_we, .mem_busy, .io_pin_oe_n,
   .io_pin_push_pull, .second_regulator_en, .out_pin_level, .out_pin_oe_n,
   .out_pin_output_style, .sync_clk_on);
`default_nettype wire

// file: test/pir_tb_master.sv
/* Bus master model, open drain on both lines.
 Assumes pull-ups on the wires outside. */
`timescale 1ns/10ps
`default_nettype none
module pir_tb_master (
   // Clock and wires
   input  wire logic core_clk,
   input  wire logic scl,
   input  wire logic sda,
   // Pull-downs and hang flag
   output logic      scl_low = 1'b0,
   output logic      sda_low = 1'b0,
   output logic      hung = 1'b0
);
   localparam int HALF = 12;
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_n
   // Slave may stretch; wait is bounded
   task automatic rel_scl();
      int k;
      scl_low <= 1'b0;
      for (k = 0; k < 4000 && scl !== 1'b1; k++) @(posedge core_clk);
      if (k == 4000) hung <= 1'b1;
   endtask : rel_scl
   // Data moves 4 cycles after clock falls
   task automatic bit_out(input logic b);
      sda_low <= !b;
      wait_n(HALF);
      rel_scl();
      wait_n(HALF);
      scl_low <= 1'b1;
      wait_n(4);
   endtask : bit_out
   task automatic bit_in(output logic b);
      sda_low <= 1'b0;
      wait_n(HALF);
      rel_scl();
      wait_n(HALF);
      b = sda;
      scl_low <= 1'b1;
      wait_n(4);
   endtask : bit_in
   // Also serves as repeated start
   task automatic start();
      sda_low <= 1'b0;
      wait_n(HALF);
      rel_scl();
      wait_n(HALF);
      sda_low <= 1'b1;
      wait_n(HALF);
      scl_low <= 1'b1;
      wait_n(4);
   endtask : start
   task automatic stop();
      sda_low <= 1'b1;
      wait_n(HALF);
      rel_scl();
      wait_n(HALF);
      sda_low <= 1'b0;
      wait_n(HALF);
   endtask : stop
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(b);
      ack = !b;
   endtask : wr_byte
   task automatic rd_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(last);
   endtask : rd_byte
endmodule : pir_tb_master
`default_nettype wire

// file: test/tb_pmu_i2c_slave_regs.sv
/* Testbench for the slave front end.
 Assumes the master model and memory stub below. */
`timescale 1ns/10ps
`default_nettype none
module tb_pmu_i2c_slave_regs;
   import pir_pkg::*;
   localparam logic [3:0] DEV = 4'h6;  // Arbitrary value
   localparam logic [3:0] REV = 4'h3;  // Arbitrary value
   localparam logic [6:0] MREV = 7'h15; // Arbitrary value
   logic core_clk = 1'b0, sys_rst = 1'b1, undervoltage_lockout = 1'b1;
   logic mem_busy = 1'b0, io_pin_in = 1'b0, scl_oe_n, sda_oe_n, m_scl, m_sda, hung;
   logic scl_out, sda_out, mem_we, io_pin_out, io_pin_oe_n, io_pin_push_pull;
   logic second_regulator_en, out_pin_level, out_pin_oe_n, out_pin_output_style;
   logic sync_clk_on, a0, a1, a2;
   logic [11:0] mem_addr, we_addr, ma;
   logic [7:0] mem_wdata, we_data, d, q0, q1, q2;
   wire logic [7:0] mem_rdata = mem_addr[7:0] ^ 8'hA5;
   wire logic scl_w = !(m_scl || !scl_oe_n);
   wire logic sda_w = !(m_sda || !sda_oe_n);
   int n_mismatch = 0, n_compared = 0, n_we = 0, busy_cnt = 0, seed, w0;
   always #2.5 core_clk = !core_clk;
   pir_i2c_slave #(.DEVICE_CODE(DEV), .DIE_REV_CODE(REV), .MEM_REV_CODE(MREV)) i_dut (
      .core_clk, .sys_rst, .undervoltage_lockout, .scl_in(scl_w), .scl_out, .scl_oe_n,
      .sda_in(sda_w), .sda_out, .sda_oe_n, .mem_addr, .mem_wdata, .mem_we, .mem_busy,
      .mem_rdata, .io_pin_out, .io_pin_oe_n, .io_pin_push_pull, .io_pin_in,
      .second_regulator_en, .out_pin_level, .out_pin_oe_n, .out_pin_output_style,
      .sync_clk_on);
   pir_tb_master i_mst (.core_clk, .scl(scl_w), .sda(sda_w), .scl_low(m_scl),
      .sda_low(m_sda), .hung);
   // Memory stub: log writes, stay busy a while to force stretching
   always @(posedge core_clk) begin
      if (mem_we === 1'b1) begin
         n_we <= n_we + 1;
         we_addr <= mem_addr;
         we_data <= mem_wdata;
         busy_cnt <= 20;
      end else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      mem_busy <= (busy_cnt > 1);
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Expected pad outputs for a register value and pin level
   function automatic logic [7:0] pad_exp(input logic [7:0] r, input logic pin);
      return {1'b0, r[3], !r[5], !r[4] | (r[3] & r[5]), !r[4] & pin, r[1], r[0], r[0] & r[1]};
   endfunction : pad_exp
   task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] v);
      i_mst.start();
      i_mst.wr_byte({PIR_ADDR_REGS, 1'b0}, a0);
      if (!a0) begin
         i_mst.stop();
         i_mst.start();
         i_mst.wr_byte({PIR_ADDR_REGS, 1'b0}, a0);
      end
      i_mst.wr_byte(ofs, a1);
      i_mst.wr_byte(v, a2);
      i_mst.stop();
      check({5'h0, a0, a1, a2}, 8'h07);
   endtask : reg_wr
   // Offset write, repeated start, one byte read if n is 1 else three, nack on the last
   task automatic reg_rd(input logic [7:0] ofs, input int n);
      i_mst.start();
      i_mst.wr_byte({PIR_ADDR_REGS, 1'b0}, a0);
      i_mst.wr_byte(ofs, a1);
      i_mst.start();
      i_mst.wr_byte({PIR_ADDR_REGS, 1'b1}, a2);
      i_mst.rd_byte(n == 1, q0);
      if (n > 1) i_mst.rd_byte(1'b0, q1);
      if (n > 1) i_mst.rd_byte(1'b1, q2);
      i_mst.stop();
      check({5'h0, a0, a1, a2}, 8'h07);
   endtask : reg_rd
   task automatic mem_wr(input logic [15:0] ad, input logic [7:0] v);
      i_mst.start();
      i_mst.wr_byte({PIR_ADDR_MEM, 1'b0}, a0);
      i_mst.wr_byte(ad[7:0], a1);
      i_mst.wr_byte(ad[15:8], a2);
      i_mst.wr_byte(v, a2);
      i_mst.stop();
   endtask : mem_wr
   task automatic summarize();
      if (hung === 1'b1) n_mismatch++;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   always @(posedge hung) summarize();
   initial begin
      seed = $urandom(4);
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      undervoltage_lockout <= 1'b0;
      repeat (8) @(posedge core_clk);
      // Lone start after power-up, then stop
      i_mst.start();
      repeat (20) @(posedge core_clk);
      check({7'h0, sync_clk_on}, 8'h01);
      i_mst.stop();
      repeat (20) @(posedge core_clk);
      check({7'h0, sync_clk_on}, 8'h00);
      // Read-only write ignored, then burst over all three registers
      reg_wr(PIR_OFS_IDENT, 8'hFF);
      reg_rd(PIR_OFS_IDENT, 3);
      check(q0, {DEV, REV});
      check(q1, {1'b0, MREV});
      check(q2, PIR_PAD_RESET);
      for (int i = 0; i < 2; i++) begin
         reg_rd((i == 0) ? 8'hFF : 8'h03 + 8'($urandom % 253), 1);
         check(q0, PIR_READ_UNMAP);
      end
      // Pad register: corner values then random
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         io_pin_in <= 1'($urandom);
         reg_wr(PIR_OFS_PAD, d);
         repeat (8) @(posedge core_clk);
         check({1'b0, io_pin_out, io_pin_push_pull, io_pin_oe_n, second_regulator_en,
            out_pin_output_style,
            out_pin_level, out_pin_oe_n}, pad_exp(d, io_pin_in));
         reg_rd(PIR_OFS_PAD, 1);
         check(q0, d & PIR_PAD_WMASK);
      end
      // Memory writes, top address first, two random, then one beyond range
      for (int j = 0; j < 4; j++) begin
         ma = (j == 0) ? PIR_MEM_TOP : 12'($urandom);
         d = 8'($urandom);
         w0 = n_we;
         mem_wr((j == 3) ? 16'h1000 : {4'h0, ma}, d);
         check(8'(n_we - w0), (j == 3) ? 8'h00 : 8'h01);
         if (j < 3) check(we_addr[7:0], ma[7:0]);
         if (j < 3) check({4'h0, we_addr[11:8]}, {4'h0, ma[11:8]});
         if (j < 3) check(we_data, d);
      end
      // Memory read back in range, then beyond range reads zero
      for (int j = 0; j < 2; j++) begin
         ma = 12'($urandom);
         i_mst.start();
         i_mst.wr_byte({PIR_ADDR_MEM, 1'b0}, a0);
         i_mst.wr_byte(ma[7:0], a1);
         i_mst.wr_byte({3'h0, j[0], ma[11:8]}, a2);
         i_mst.start();
         i_mst.wr_byte({PIR_ADDR_MEM, 1'b1}, a2);
         i_mst.rd_byte(1'b1, q0);
         i_mst.stop();
         check({5'h0, a0, a1, a2}, 8'h07);
         check(q0, (j == 0) ? (ma[7:0] ^ 8'hA5) : 8'h00);
      end
      // Foreign address is not acknowledged
      i_mst.start();
      i_mst.wr_byte(8'h66, a0);
      i_mst.stop();
      check({7'h0, a0}, 8'h00);
      // Lockout in mid-transfer resets the interface and pad register
      i_mst.start();
      i_mst.wr_byte({PIR_ADDR_REGS, 1'b0}, a0);
      undervoltage_lockout <= 1'b1;
      repeat (4) @(posedge core_clk);
      undervoltage_lockout <= 1'b0;
      i_mst.stop();
      reg_rd(PIR_OFS_PAD, 1);
      check(q0, PIR_PAD_RESET);
      summarize();
   end
endmodule : tb_pmu_i2c_slave_regs
`default_nettype wire
